// ==== rws_reset_ctrl.v ====
// rws_reset_ctrl.v: power-on and watchdog reset sequencing, semi-suspend timing,
// write-to-clear watchdog, reset-cause flags and suspend entry and wake.
// assumes the core's I/O write strobe, address and data are synchronous to clk_i,
// and that por_i is the analog power-on detector already synchronised.
//
// How it works
// RULE_01 - any reset restores registers, clears USB addresses, interrupts, both stack pointers
// RULE_02 - reset cause is kept in status bit 4 (power-on) and bit 6 (watchdog)
// RULE_03 - after reset, fetch starts at 0x0000 with nothing pushed on the stack
// RULE_04 - during power-on reset and semi-suspend the core is stopped, clocks keep running
// RULE_05 - after power-on release, 1 ms locked hold then 95 ms more before code runs
// RULE_06 - upstream bus reset during the 95 ms ends semi-suspend, execution starts at 0x0000
// RULE_07 - bus reset interrupt stays pending until firmware enables it and interrupts
// RULE_08 - each power-on reset reassert and release replays the whole semi-suspend sequence
// RULE_09 - any write to watchdog clear at 0x26 restarts the watchdog from zero
// RULE_10 - watchdog not cleared within its timeout rolls over into a watchdog reset
// RULE_11 - watchdog reset loads the status register with 010X0001
// RULE_12 - watchdog reset holds the core 2 ms, then starts at address 0x0000
// RULE_13 - after a watchdog reset the USB transmitter stays disabled
// RULE_14 - firmware ignores the watchdog flag while the power-on flag is set
// RULE_15 - suspend bit stops oscillator, PLL, free-running timer and watchdog
// RULE_16 - only an enabled GPIO interrupt or USB non-idle activity wakes from suspend
// RULE_17 - firmware sets suspend and run together, e.g. 09h to register FFh
// RULE_18 - on wake the oscillator restarts at once; core runs 1 ms after it is stable
// RULE_19 - after wake the next instruction executes before any pending interrupt
// RULE_20 - bus reset during the first locked millisecond does not abort semi-suspend
`timescale 1ns/1ps
`include "rws_consts.vh"
module rws_reset_ctrl #(
   parameter LOCK_CYC    = `RWS_US_TO_CYC(`RWS_T_LOCK_US),
   parameter SEMI_CYC    = `RWS_US_TO_CYC(`RWS_T_SEMI_US),
   parameter WDRST_CYC   = `RWS_US_TO_CYC(`RWS_T_WDOG_RST_US),
   parameter WAKE_CYC    = `RWS_US_TO_CYC(`RWS_T_WAKE_US),
   parameter WATCH_CYC   = `RWS_US_TO_CYC(`RWS_T_WATCH_US),
   parameter TW          = 24
) (
   input  wire        clk_i,
   input  wire        reset_n_i,
   input  wire        por_i,
   input  wire        osc_stable_i,
   input  wire        io_wr_i,
   input  wire [7:0]  io_addr_i,
   input  wire [7:0]  io_wdata_i,
   input  wire        io_rd_i,
   input  wire        usb_bus_reset_i,
   input  wire        usb_activity_i,
   input  wire        gpio_irq_i,
   input  wire        bus_reset_irq_en_i,
   input  wire        global_irq_en_i,
   input  wire        reset_handler_done_i,
   output reg  [7:0]  io_rdata_o,
   output reg         cpu_hold_o,
   output reg         sys_reset_o,
   output reg  [13:0] pc_load_value_o,
   output reg         pc_load_o,
   output reg  [7:0]  program_stack_pointer_o,
   output reg  [7:0]  data_stack_pointer_o,
   output reg         usb_addr_clear_o,
   output reg         irq_disable_o,
   output reg         usb_tx_disable_o,
   output reg         bus_reset_pending_o,
   output reg         irq_block_o,
   output reg         osc_enable_o,
   output reg         timers_enable_o,
   output reg         suspended_o
);
   localparam [2:0] ST_POR     = 3'd0;
   localparam [2:0] ST_LOCK    = 3'd1;
   localparam [2:0] ST_SEMI    = 3'd2;
   localparam [2:0] ST_RUN     = 3'd3;
   localparam [2:0] ST_WDRST   = 3'd4;
   localparam [2:0] ST_SUSPEND = 3'd5;
   localparam [2:0] ST_WAKE    = 3'd6;

   reg  [2:0]    state_reg;
   reg  [2:0]    state_next;
   reg  [7:0]    status_reg;
   reg           tmr_load;
   reg  [TW-1:0] tmr_count;
   wire          tmr_done;
   wire          tmr_busy;
   reg  [TW-1:0] wdog_reg;
   reg           wdog_fire;
   reg           post_wake_reg;

   wire wr_status = io_wr_i && (io_addr_i == `RWS_ADDR_STATUS_CTRL);
   wire wr_wdog   = io_wr_i && (io_addr_i == `RWS_ADDR_WDOG_CLEAR);
   wire wake_req  = usb_activity_i || gpio_irq_i;
   wire wdog_live = (state_reg == ST_RUN);

   rws_timer #(
      .WIDTH     (TW)
   ) u_timer (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .run_i     (state_reg != ST_WAKE || osc_stable_i),
      .done_o    (tmr_done),
      .busy_o    (tmr_busy)
   );

   // watchdog counts only while the core runs; any hold or suspend restarts it from zero
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         wdog_reg  <= {TW{1'b0}};
         wdog_fire <= 1'b0;
      end else begin
         wdog_fire <= 1'b0;
         if (!wdog_live || wr_wdog) begin
            wdog_reg <= {TW{1'b0}}; // RULE_09
         end else if (wdog_reg == WATCH_CYC[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}) begin
            wdog_reg  <= {TW{1'b0}};
            wdog_fire <= 1'b1; // RULE_10
         end else begin
            wdog_reg <= wdog_reg + {{(TW-1){1'b0}}, 1'b1};
         end
      end
   end

   always @* begin
      state_next = state_reg;
      tmr_load   = 1'b0;
      tmr_count  = {TW{1'b0}};
      if (por_i) begin
         state_next = ST_POR; // RULE_08
      end else begin
         case (state_reg)
            ST_POR: begin
               state_next = ST_LOCK;
               tmr_load   = 1'b1;
               tmr_count  = LOCK_CYC[TW-1:0]; // RULE_05
            end
            ST_LOCK: begin
               // bus reset is not looked at here
               if (tmr_done) begin // RULE_20
                  state_next = ST_SEMI;
                  tmr_load   = 1'b1;
                  tmr_count  = SEMI_CYC[TW-1:0]; // RULE_05
               end
            end
            ST_SEMI: begin
               if (usb_bus_reset_i || tmr_done) begin
                  state_next = ST_RUN; // RULE_06
               end
            end
            ST_RUN: begin
               if (wdog_fire) begin
                  state_next = ST_WDRST;
                  tmr_load   = 1'b1;
                  tmr_count  = WDRST_CYC[TW-1:0]; // RULE_12
               end else if (wr_status && io_wdata_i[`RWS_BIT_SUSPEND]) begin
                  state_next = ST_SUSPEND; // RULE_15
               end
            end
            ST_WDRST: begin
               if (tmr_done) begin
                  state_next = ST_RUN; // RULE_12
               end
            end
            ST_SUSPEND: begin
               if (wake_req) begin // RULE_16
                  state_next = ST_WAKE;
                  tmr_load   = 1'b1;
                  tmr_count  = WAKE_CYC[TW-1:0]; // RULE_18
               end
            end
            ST_WAKE: begin
               if (tmr_done) begin
                  state_next = ST_RUN;
               end
            end
            default: begin
               state_next = ST_POR;
            end
         endcase
      end
   end

   wire enter_run = (state_next == ST_RUN) &&
                    (state_reg == ST_SEMI || state_reg == ST_WDRST);
   wire any_reset = (state_next == ST_POR) || (state_next == ST_WDRST && state_reg == ST_RUN);

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg               <= ST_POR;
         status_reg              <= `RWS_STATUS_POR_VALUE;
         io_rdata_o              <= 8'h00;
         cpu_hold_o              <= 1'b1;
         sys_reset_o             <= 1'b1;
         pc_load_value_o         <= `RWS_PC_RESET;
         pc_load_o               <= 1'b0;
         program_stack_pointer_o <= `RWS_SP_RESET;
         data_stack_pointer_o    <= `RWS_SP_RESET;
         usb_addr_clear_o        <= 1'b1;
         irq_disable_o           <= 1'b1;
         usb_tx_disable_o        <= 1'b0;
         bus_reset_pending_o     <= 1'b0;
         irq_block_o             <= 1'b0;
         osc_enable_o            <= 1'b1;
         timers_enable_o         <= 1'b1;
         suspended_o             <= 1'b0;
         post_wake_reg           <= 1'b0;
      end else begin
         state_reg <= state_next;
         // held stopped in every state except run; oscillator keeps going in semi-suspend
         cpu_hold_o      <= (state_next != ST_RUN); // RULE_04
         osc_enable_o    <= (state_next != ST_SUSPEND); // RULE_15
         timers_enable_o <= (state_next != ST_SUSPEND) && (state_next != ST_WAKE); // RULE_15
         suspended_o     <= (state_next == ST_SUSPEND);
         sys_reset_o     <= (state_next == ST_POR) || (state_next == ST_LOCK) ||
                            (state_next == ST_SEMI) || (state_next == ST_WDRST); // RULE_01
         usb_addr_clear_o <= any_reset; // RULE_01
         irq_disable_o    <= any_reset; // RULE_01
         pc_load_o        <= enter_run; // RULE_03
         pc_load_value_o  <= `RWS_PC_RESET; // RULE_03
         if (any_reset) begin
            program_stack_pointer_o <= `RWS_SP_RESET; // RULE_01
            data_stack_pointer_o    <= `RWS_SP_RESET; // RULE_01
         end
         // placed first so a watchdog entry in the same cycle still turns tx off
         if (reset_handler_done_i) begin
            usb_tx_disable_o <= 1'b0;
         end
         if (state_next == ST_POR) begin
            status_reg       <= `RWS_STATUS_POR_VALUE; // RULE_02
            usb_tx_disable_o <= 1'b0;
         end else if (state_next == ST_WDRST && state_reg == ST_RUN) begin
            // bit 4 survives only as the don't-care position of the pattern
            status_reg <= `RWS_STATUS_WDOG_VALUE |
                          (status_reg & (8'h01 << `RWS_BIT_POR_FLAG)); // RULE_11
            usb_tx_disable_o <= 1'b1; // RULE_13
         end else if (wr_status) begin
            // flag bits are write-to-clear free: the mask keeps firmware writes off bits 4 and 6
            status_reg <= (io_wdata_i & `RWS_STATUS_WMASK) |
                          (status_reg & ~`RWS_STATUS_WMASK);
         end else if (state_reg == ST_SUSPEND && state_next == ST_WAKE) begin
            status_reg[`RWS_BIT_SUSPEND] <= 1'b0;
         end
         // bus reset that ends semi-suspend becomes a pending interrupt
         if (state_reg == ST_SEMI && usb_bus_reset_i) begin
            bus_reset_pending_o <= 1'b1; // RULE_07
         end else if (bus_reset_irq_en_i && global_irq_en_i) begin
            bus_reset_pending_o <= 1'b0; // RULE_07
         end
         // one instruction slot after wake runs before any interrupt is taken
         if (state_reg == ST_WAKE && state_next == ST_RUN) begin
            post_wake_reg <= 1'b1; // RULE_19
         end else if (io_rd_i || io_wr_i || reset_handler_done_i) begin
            post_wake_reg <= 1'b0;
         end
         // the wake-to-run edge itself is covered before post_wake_reg is set
         irq_block_o <= post_wake_reg || (state_reg == ST_WAKE) ||
                        (state_next != ST_RUN); // RULE_19
         if (io_rd_i && io_addr_i == `RWS_ADDR_STATUS_CTRL) begin
            io_rdata_o <= status_reg;
         end else begin
            io_rdata_o <= 8'h00;
         end
      end
   end
endmodule // rws_reset_ctrl

// ==== rws_consts.vh ====
// rws_consts.vh: offsets, status-control field positions, reset values and timing for the
// reset, watchdog and suspend controller. definitions only.
`ifndef RWS_CONSTS_VH
`define RWS_CONSTS_VH

`define RWS_ADDR_WDOG_CLEAR     8'h26
`define RWS_ADDR_STATUS_CTRL    8'hFF

// status and control fields
`define RWS_BIT_RUN             0
`define RWS_BIT_SUSPEND         3
`define RWS_BIT_POR_FLAG        4
`define RWS_BIT_WDOG_FLAG       6
`define RWS_STATUS_POR_VALUE    8'h11
`define RWS_STATUS_WDOG_VALUE   8'h41
`define RWS_STATUS_WMASK        8'hAF

`define RWS_PC_RESET            14'h0000
`define RWS_SP_RESET            8'h00

// times in microseconds, clock in kHz
`define RWS_CLK_KHZ             125000
`define RWS_T_LOCK_US           1000
`define RWS_T_SEMI_US           95000
`define RWS_T_WDOG_RST_US       2000
`define RWS_T_WAKE_US           1000
`define RWS_T_WATCH_US          8000
// divide first: 95000 us times the kHz figure overflows 32-bit integer arithmetic
`define RWS_US_TO_CYC(t)        ((t) * (`RWS_CLK_KHZ / 1000))

`endif

// ==== rws_timer.v ====
// rws_timer.v: loadable down counter with one-cycle expiry pulse.
// assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rws_timer #(
   parameter WIDTH = 24
) (
   input  wire             clk_i,
   input  wire             reset_n_i,
   input  wire             load_i,
   input  wire [WIDTH-1:0] count_i,
   input  wire             run_i,
   output reg              done_o,
   output wire             busy_o
);
   reg [WIDTH-1:0] cnt_reg;

   assign busy_o = (cnt_reg != {WIDTH{1'b0}});

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt_reg <= {WIDTH{1'b0}};
         done_o  <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (load_i) begin
            cnt_reg <= count_i;
         end else if (run_i && busy_o) begin
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
            done_o  <= (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule // rws_timer

// ==== rws_reset_ctrl_assertions.sv ====
// rws_reset_ctrl_assertions.sv: port-level timing checks for the reset controller.
// assumes the bench's shortened cycle counts are handed on by the bind below.
`timescale 1ns/1ps
module rws_reset_ctrl_assertions #(
   parameter LOCK_CYC = 10, SEMI_CYC = 40, WDRST_CYC = 20, WATCH_CYC = 50
) (
   input wire        clk_i,
   input wire        reset_n_i,
   input wire        por_i,
   input wire        io_wr_i,
   input wire        usb_activity_i,
   input wire        gpio_irq_i,
   input wire        bus_reset_irq_en_i,
   input wire        global_irq_en_i,
   input wire        cpu_hold_o,
   input wire        sys_reset_o,
   input wire        pc_load_o,
   input wire        usb_tx_disable_o,
   input wire        bus_reset_pending_o,
   input wire        irq_block_o,
   input wire        osc_enable_o,
   input wire        timers_enable_o,
   input wire        suspended_o,
   input wire [7:0]  io_addr_i,
   input wire [7:0]  io_wdata_i,
   input wire [7:0]  program_stack_pointer_o,
   input wire [7:0]  data_stack_pointer_o,
   input wire [13:0] pc_load_value_o
);
   localparam int WD_LO = WDRST_CYC - 11;
   localparam int WD_HI = WDRST_CYC - 3;
   logic [23:0] hold_cnt;
   logic [23:0] quiet_cnt;
   // quiet_cnt counts run cycles since the last watchdog clear
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         hold_cnt  <= 24'h0;
         quiet_cnt <= 24'h0;
      end else begin
         hold_cnt  <= (cpu_hold_o && !por_i) ? hold_cnt + 24'h1 : 24'h0;
         quiet_cnt <= (cpu_hold_o || suspended_o || (io_wr_i && io_addr_i == 8'h26)) ?
                      24'h0 : quiet_cnt + 24'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence wd_entry_s; $rose(usb_tx_disable_o); endsequence
   sequence wd_exit_s; !pc_load_o [*8] ##[WD_LO:WD_HI] pc_load_o; endsequence
   a_por_hold: assert property (por_i |=> cpu_hold_o && sys_reset_o && osc_enable_o)
      else $error("core not held under power-on reset");
   a_start_clean: assert property (pc_load_o |-> pc_load_value_o == 14'h0000 &&
      program_stack_pointer_o == 8'h00 && data_stack_pointer_o == 8'h00)
      else $error("start address or stack pointers not zero");
   a_hold_span: assert property (pc_load_o |-> hold_cnt >= LOCK_CYC &&
      hold_cnt <= LOCK_CYC + SEMI_CYC + 4) else $error("hold length out of range");
   a_pending_kept: assert property (bus_reset_pending_o && !por_i &&
      !(bus_reset_irq_en_i && global_irq_en_i) |=> bus_reset_pending_o)
      else $error("bus reset pending lost");
   a_wdog_entry: assert property (wd_entry_s |-> cpu_hold_o && sys_reset_o)
      else $error("watchdog reset without core hold");
   a_wdog_release: assert property (wd_entry_s |-> wd_exit_s)
      else $error("watchdog hold length wrong");
   a_wdog_timeout: assert property (wd_entry_s |-> quiet_cnt >= WATCH_CYC - 3 &&
      quiet_cnt <= WATCH_CYC + 3) else $error("watchdog fired at wrong time");
   a_suspend_entry: assert property (io_wr_i && io_addr_i == 8'hFF && io_wdata_i[3] &&
      !cpu_hold_o && !suspended_o |-> ##[1:2] suspended_o && !osc_enable_o && !timers_enable_o)
      else $error("suspend did not stop clocks");
   a_wake_cause: assert property ($fell(suspended_o) |-> osc_enable_o &&
      ($past(usb_activity_i) || $past(gpio_irq_i) || $past(usb_activity_i, 2) ||
      $past(gpio_irq_i, 2))) else $error("wake without cause or oscillator");
   a_wake_block: assert property ($fell(cpu_hold_o) && !pc_load_o |-> irq_block_o)
      else $error("interrupts not held off after wake");
endmodule // rws_reset_ctrl_assertions
bind rws_reset_ctrl rws_reset_ctrl_assertions #(.LOCK_CYC(LOCK_CYC), .SEMI_CYC(SEMI_CYC),
   .WDRST_CYC(WDRST_CYC), .WATCH_CYC(WATCH_CYC)) i_rws_chk (.clk_i(clk_i),
   .reset_n_i(reset_n_i), .por_i(por_i), .io_wr_i(io_wr_i), .usb_activity_i(usb_activity_i),
   .gpio_irq_i(gpio_irq_i), .bus_reset_irq_en_i(bus_reset_irq_en_i),
   .global_irq_en_i(global_irq_en_i), .cpu_hold_o(cpu_hold_o), .sys_reset_o(sys_reset_o),
   .pc_load_o(pc_load_o), .usb_tx_disable_o(usb_tx_disable_o),
   .bus_reset_pending_o(bus_reset_pending_o), .irq_block_o(irq_block_o),
   .osc_enable_o(osc_enable_o),
   .timers_enable_o(timers_enable_o), .suspended_o(suspended_o), .io_addr_i(io_addr_i),
   .io_wdata_i(io_wdata_i), .program_stack_pointer_o(program_stack_pointer_o),
   .data_stack_pointer_o(data_stack_pointer_o), .pc_load_value_o(pc_load_value_o));

// ==== rws_core_model.sv ====
// rws_core_model.sv: stand-in for the core's I/O bus, the upstream USB port and the oscillator.
// assumes its tasks are called on the falling edge of clk_i.
`timescale 1ns/1ps
module rws_core_model (
   input  wire        clk_i,
   input  wire        osc_enable_i,
   input  wire  [7:0] io_rdata_i,
   output logic       io_wr_o,
   output logic       io_rd_o,
   output logic [7:0] io_addr_o,
   output logic [7:0] io_wdata_o,
   output logic       usb_bus_reset_o,
   output logic       usb_activity_o,
   output logic       osc_stable_o
);
   logic [1:0] settle = 2'h0;
   initial {io_wr_o, io_rd_o, io_addr_o, io_wdata_o, usb_bus_reset_o, usb_activity_o} = '0;
   initial osc_stable_o = 1'b0;
   // the oscillator needs a few cycles to settle after each restart
   always @(posedge clk_i) begin
      settle       <= osc_enable_i ? settle + {1'b0, settle != 2'h3} : 2'h0;
      osc_stable_o <= osc_enable_i && settle == 2'h3;
   end
   // idle bus shows inverted values so stale data cannot pass for fresh
   task wr(input logic [7:0] a, input logic [7:0] d);
      io_wr_o    = 1'b1;
      io_addr_o  = a;
      io_wdata_o = d;
      @(negedge clk_i);
      io_wr_o    = 1'b0;
      io_addr_o  = ~a;
      io_wdata_o = ~d;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      io_rd_o   = 1'b1;
      io_addr_o = a;
      @(negedge clk_i);
      d         = io_rdata_i;
      io_rd_o   = 1'b0;
      io_addr_o = ~a;
   endtask
   task usb_pulse(input logic rst, input int n);
      usb_bus_reset_o = rst;
      usb_activity_o  = !rst;
      repeat (n) @(negedge clk_i);
      usb_bus_reset_o = 1'b0;
      usb_activity_o  = 1'b0;
   endtask
endmodule // rws_core_model

// ==== rws_reset_ctrl_tb_top.sv ====
// rws_reset_ctrl_tb_top.sv: self-checking bench for the reset, watchdog and suspend controller.
// assumes shortened cycle counts; all inputs except osc_stable_i change on the falling clock edge.
`timescale 1ns/1ps
module rws_reset_ctrl_tb_top;
   localparam int LOCK = 10, SEMI = 40, WDRST = 20, WAKE = 10, WATCH = 50;
   logic clk_i = 1'b0, reset_n_i = 1'b0, por_i = 1'b0, gpio = 1'b0;
   logic br_en = 1'b0, gl_en = 1'b0, done = 1'b0;
   logic [7:0] rv;
   wire io_wr, io_rd, usb_rst, usb_act, osc_ok, hold, srst, pcl, txd, pend, osc_en, tmr_en, susp;
   wire blk, aclr, idis;
   wire [7:0] addr, wdata, rdata, program_stack_pointer, dsp;
   wire [13:0] pcv;
   int miscompares = 0, comparisons = 0, n;
   rws_reset_ctrl #(.LOCK_CYC(LOCK), .SEMI_CYC(SEMI), .WDRST_CYC(WDRST), .WAKE_CYC(WAKE),
      .WATCH_CYC(WATCH)) i_rws_reset_ctrl (.clk_i(clk_i), .reset_n_i(reset_n_i), .por_i(por_i),
      .osc_stable_i(osc_ok), .io_wr_i(io_wr), .io_addr_i(addr), .io_wdata_i(wdata),
      .io_rd_i(io_rd), .usb_bus_reset_i(usb_rst), .usb_activity_i(usb_act), .gpio_irq_i(gpio),
      .bus_reset_irq_en_i(br_en), .global_irq_en_i(gl_en), .reset_handler_done_i(done),
      .io_rdata_o(rdata), .cpu_hold_o(hold), .sys_reset_o(srst), .pc_load_value_o(pcv),
      .pc_load_o(pcl), .program_stack_pointer_o(program_stack_pointer), .data_stack_pointer_o(dsp),
      .usb_addr_clear_o(aclr), .irq_disable_o(idis), .usb_tx_disable_o(txd),
      .bus_reset_pending_o(pend), .irq_block_o(blk), .osc_enable_o(osc_en),
      .timers_enable_o(tmr_en), .suspended_o(susp));
   rws_core_model i_rws_core_model (.clk_i(clk_i), .osc_enable_i(osc_en), .io_rdata_i(rdata),
      .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(addr), .io_wdata_o(wdata),
      .usb_bus_reset_o(usb_rst), .usb_activity_o(usb_act), .osc_stable_o(osc_ok));
   initial forever #4 clk_i = ~clk_i;
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task stop_test;
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      miscompares++;
      stop_test;
   end
   initial begin
      cyc(8);
      reset_n_i = 1'b1;
      cyc(3);
      i_rws_core_model.usb_pulse(1'b1, 2);
      chk("hold in lock", 1, hold);
      cyc(LOCK);
      chk("hold in semi", 2'b11, {hold, srst});
      i_rws_core_model.usb_pulse(1'b1, 1);
      for (n = 0; pcl !== 1'b1 && n < 4; n++) cyc(1);
      chk("abort load", 1, pcl);
      chk("stack pointers", 0, {program_stack_pointer, dsp});
      chk("start address", 0, pcv);
      cyc(1);
      chk("run and pending", 2'b01, {hold, pend});
      i_rws_core_model.rd(8'hFF, rv);
      chk("status after power-on", 8'h11, rv);
      br_en = 1'b1;
      cyc(2);
      chk("pending kept", 1, pend);
      gl_en = 1'b1;
      cyc(2);
      chk("pending cleared", 0, pend);
      br_en = 1'b0;
      gl_en = 1'b0;
      for (n = 0; n < 3; n++) begin
         cyc(30);
         i_rws_core_model.wr(8'h26, 8'(n * 8'h7F));
      end
      chk("watchdog cleared", 2'b00, {txd, hold});
      for (n = 0; txd !== 1'b1 && n < 60; n++) cyc(1);
      chk("watchdog timeout", 1, n >= WATCH - 3 && n <= WATCH + 3);
      chk("reset pulses", 2'b11, {aclr, idis});
      chk("watchdog hold", 1, hold);
      for (n = 0; pcl !== 1'b1 && n < 40; n++) cyc(1);
      chk("watchdog release", 1, n >= WDRST - 4 && n <= WDRST + 4);
      cyc(1);
      i_rws_core_model.rd(8'hFF, rv);
      chk("status after watchdog", 8'h51, rv);
      chk("tx still off", 1, txd);
      done = 1'b1;
      cyc(1);
      done = 1'b0;
      cyc(1);
      chk("tx back on", 0, txd);
      for (int i = 0; i < 2; i++) begin
         cyc(1);
         i_rws_core_model.wr(8'h26, 8'hA5);
         cyc(1);
         i_rws_core_model.wr(8'hFF, 8'h09);
         cyc(2);
         chk("suspended", 3'b100, {susp, osc_en, tmr_en});
         cyc(10);
         chk("no idle wake", 1, susp);
         if (i == 0) i_rws_core_model.usb_pulse(1'b0, 2);
         else begin
            gpio = 1'b1;
            cyc(2);
            gpio = 1'b0;
         end
         chk("woken", 2'b01, {susp, osc_en});
         cyc(WAKE + 12);
         chk("running after wake", 0, hold);
         chk("wake slot", 1, blk);
         i_rws_core_model.rd(8'hFF, rv);
         chk("status after wake", 8'h51, rv);
      end
      por_i = 1'b1;
      cyc(3);
      chk("power-on hold", 4'hF, {hold, srst, aclr, idis});
      por_i = 1'b0;
      for (n = 0; hold !== 1'b0 && n < 80; n++) cyc(1);
      chk("semi-suspend length", 1, n >= LOCK + SEMI - 2 && n <= LOCK + SEMI + 4);
      i_rws_core_model.rd(8'hFF, rv);
      chk("status after repeat", 8'h11, rv);
      stop_test;
   end
endmodule // rws_reset_ctrl_tb_top
